// >>> hw/ttc_timer_counter.sv
// triggered timer/counter: control flip-flop, timebase and counter
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R1 - trigger high sets run state
// R2 - reset high, trigger low, stops
// R3 - trigger wins over reset
// R4 - entering run loads all zeros
// R5 - count on each falling timebase edge
// R6 - stopped: outputs high, counting held
// R7 - stopped halts oscillator unless external timebase
// R8 - oscillator gives one cycle per rc period
// R9 - no feedback means free running
// R10 - wired outputs reset at programmed count
// R11 - outside wires outputs with shared pull-up
// R12 - fixed variant: divide-by-2 and divide-by-256
// R13 - grounded timing node selects external clock
// R14 - one-shot: outside feeds divide-by-256 to reset
// R15 - divider: trigger reasserted after reset
// R16 - divider delays below half timebase period
// R17 - buffered reset line on its own output
// R18 - all stages clocked on same edge
// R19 - trigger with timebase high waits for edge
// R20 - carry high during last ten counts; carry stays low in binary and fixed variants
// R21 - free run wraps at variant maximum
module ttc_timer_counter #(
    parameter ttc_pkg::ttc_variant_t VARIANT = ttc_pkg::TTC_BINARY,
    parameter int RC_CYCLES = ttc_pkg::TTC_RC_CYCLES
) (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic TRIGGER_I,
    input wire logic RESET_I,
    input wire logic TIMING_NODE_GND_I,
    input wire logic TIMEBASE_PIN_I,
    output logic TIMEBASE_PIN_O,
    output logic TIMEBASE_PIN_OE_O,
    output logic [7:0] CNT_OUT_OE_O,
    output logic DIV2_O,
    output logic DIV256_O,
    output logic CARRY_O,
    output logic BUF_RESET_O,
    output logic OSC_HALT_O
);

    ttc_pkg::ttc_state_t state_r;
    logic [7:0] count_r;
    logic [7:0] count_nxt;
    logic pending_load_r;
    logic tb_prev_r;
    logic osc_out_r;
    logic [15:0] osc_cnt_r;
    logic tb_level;
    logic tb_fall;
    logic stop_req;
    logic [7:0] cnt_max;
    logic [3:0] carry_tens;
    logic bcd_mode;

    assign bcd_mode = (VARIANT == ttc_pkg::TTC_BCD) || (VARIANT == ttc_pkg::TTC_MOD60);
    assign cnt_max = (VARIANT == ttc_pkg::TTC_BCD) ? ttc_pkg::TTC_BCD_MAX :
                     (VARIANT == ttc_pkg::TTC_MOD60) ? ttc_pkg::TTC_MOD60_MAX :
                     ttc_pkg::TTC_BIN_MAX;
    assign carry_tens = (VARIANT == ttc_pkg::TTC_MOD60) ? ttc_pkg::TTC_CARRY_TENS_MOD60 :
                        ttc_pkg::TTC_CARRY_TENS_BCD;

    // R13 external clock mode
    assign tb_level = TIMING_NODE_GND_I ? TIMEBASE_PIN_I : osc_out_r;
    // R5 falling edge detect
    assign tb_fall = tb_prev_r && !tb_level;
    // R2 R3 reset only acts while trigger is low
    assign stop_req = RESET_I && !TRIGGER_I;

    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            tb_prev_r <= 1'h1;
        end else begin
            tb_prev_r <= tb_level;
        end
    end

    // R8 oscillator: low for a short discharge, period RC_CYCLES
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            osc_cnt_r <= 16'h0000;
            osc_out_r <= 1'h1;
        end else if (state_r == ttc_pkg::TTC_STOP || TIMING_NODE_GND_I) begin
            // R7 pull-up holds the timing node, oscillator stops high
            osc_cnt_r <= 16'h0000;
            osc_out_r <= 1'h1;
        end else if (osc_cnt_r == 16'(RC_CYCLES - 1)) begin
            osc_cnt_r <= 16'h0000;
            osc_out_r <= 1'h0;
        end else begin
            osc_cnt_r <= osc_cnt_r + 16'h0001;
            if (osc_cnt_r == 16'(ttc_pkg::TTC_OSC_LOW_CYCLES - 1)) begin
                osc_out_r <= 1'h1;
            end
        end
    end

    // control flip-flop
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            state_r <= ttc_pkg::TTC_STOP;
        end else begin
            case (state_r)
                ttc_pkg::TTC_STOP: begin
                    // R1 R3 trigger sets run
                    if (TRIGGER_I) begin
                        state_r <= ttc_pkg::TTC_RUN;
                    end
                end
                ttc_pkg::TTC_RUN: begin
                    // R2 R10 reset stops, R9 none means free run
                    if (stop_req) begin
                        state_r <= ttc_pkg::TTC_STOP;
                    end
                end
                default: begin
                    state_r <= ttc_pkg::TTC_STOP;
                end
            endcase
        end
    end

    // R21 wrap and bcd digit increment
    always_comb begin
        count_nxt = count_r + 8'h01;
        if (count_r == cnt_max) begin
            count_nxt = ttc_pkg::TTC_CNT_ZERO;
        end else if (bcd_mode && count_r[3:0] == ttc_pkg::TTC_DIGIT_MAX) begin
            count_nxt = {count_r[7:4] + 4'h1, 4'h0};
        end
    end

    // R18 all stages update together on one edge
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            count_r <= ttc_pkg::TTC_CNT_STOPPED;
            pending_load_r <= 1'h0;
        end else if (state_r == ttc_pkg::TTC_STOP && !TRIGGER_I) begin
            // R6 held stopped, outputs high
            count_r <= ttc_pkg::TTC_CNT_STOPPED;
            pending_load_r <= 1'h0;
        end else if (state_r == ttc_pkg::TTC_STOP) begin
            // R15 a re-asserted trigger restarts the divider cycle
            // R4 load zeros now if timebase low
            if (!tb_level) begin
                count_r <= ttc_pkg::TTC_CNT_ZERO;
                pending_load_r <= 1'h0;
            end else begin
                // R19 wait for next falling edge
                pending_load_r <= 1'h1;
            end
        end else if (stop_req) begin
            count_r <= ttc_pkg::TTC_CNT_STOPPED;
            pending_load_r <= 1'h0;
        end else if (tb_fall) begin
            if (pending_load_r) begin
                // R19 deferred load
                count_r <= ttc_pkg::TTC_CNT_ZERO;
                pending_load_r <= 1'h0;
            end else begin
                // R5 advance by one
                // R16 one-edge update keeps counter delay short
                count_r <= count_nxt;
            end
        end
    end

    // outputs registered; counter pins are open drain, enable pulls low
    always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
        if (!RSTN_I) begin
            TIMEBASE_PIN_O <= 1'h1;
            TIMEBASE_PIN_OE_O <= 1'h0;
            CNT_OUT_OE_O <= 8'h00;
            DIV2_O <= 1'h1;
            DIV256_O <= 1'h1;
            CARRY_O <= 1'h0;
            BUF_RESET_O <= 1'h0;
            OSC_HALT_O <= 1'h1;
        end else begin
            // R13 pin drives only in internal oscillator mode
            TIMEBASE_PIN_O <= osc_out_r;
            TIMEBASE_PIN_OE_O <= !TIMING_NODE_GND_I;
            // R11 released output lets the shared pull-up rise
            CNT_OUT_OE_O <= ~count_r;
            // R12 push-pull divider taps
            DIV2_O <= count_r[ttc_pkg::TTC_DIV2_BIT];
            DIV256_O <= count_r[ttc_pkg::TTC_DIV256_BIT];
            // R20 carry over last ten counts, bcd and modulo-60 variants only
            CARRY_O <= bcd_mode && state_r == ttc_pkg::TTC_RUN &&
                       count_r[7:4] == carry_tens;
            // R17 buffered counter reset line
            BUF_RESET_O <= state_r == ttc_pkg::TTC_STOP;
            // R7 pull-up on only when stopped in internal mode
            OSC_HALT_O <= state_r == ttc_pkg::TTC_STOP && !TIMING_NODE_GND_I;
        end
    end

endmodule : ttc_timer_counter
`default_nettype wire

// >>> include/ttc_pkg.sv
// constants and types for the triggered timer/counter
package ttc_pkg;
    // counter variants
    typedef enum logic [1:0] {
        TTC_BINARY = 2'h0,
        TTC_BCD = 2'h1,
        TTC_MOD60 = 2'h2,
        TTC_FIXED = 2'h3
    } ttc_variant_t;

    // control flip-flop states, one-hot
    typedef enum logic [1:0] {
        TTC_STOP = 2'h1,
        TTC_RUN = 2'h2
    } ttc_state_t;

    localparam int TTC_CNT_W = 8;
    localparam logic [7:0] TTC_CNT_ZERO = 8'h00;
    localparam logic [7:0] TTC_CNT_STOPPED = 8'hFF;
    localparam logic [7:0] TTC_BIN_MAX = 8'hFF;
    // bcd and modulo-60 counts are held as two bcd digits
    localparam logic [7:0] TTC_BCD_MAX = 8'h99;
    localparam logic [7:0] TTC_MOD60_MAX = 8'h59;
    localparam logic [3:0] TTC_DIGIT_MAX = 4'h9;
    localparam logic [3:0] TTC_CARRY_TENS_BCD = 4'h9;
    localparam logic [3:0] TTC_CARRY_TENS_MOD60 = 4'h5;
    localparam int TTC_DIV2_BIT = 0;
    localparam int TTC_DIV256_BIT = 7;
    // oscillator period in nanoseconds as a model of one rc constant
    localparam int TTC_RC_PERIOD_NS = 1000;
    localparam int TTC_CLK_PERIOD_NS = 10;
    localparam int TTC_RC_CYCLES = TTC_RC_PERIOD_NS / TTC_CLK_PERIOD_NS;
    localparam int TTC_OSC_LOW_CYCLES = 1;
endpackage : ttc_pkg

// >>> testbench/ttc_properties.sv
// port checker for the triggered timer/counter
`timescale 1ns/10ps
`default_nettype none
module ttc_chk (
    input wire logic CORE_CLK_I,
    input wire logic RSTN_I,
    input wire logic TRIGGER_I,
    input wire logic RESET_I,
    input wire logic TIMING_NODE_GND_I,
    input wire logic TIMEBASE_PIN_I,
    input wire logic TIMEBASE_PIN_OE_O,
    input wire logic [7:0] CNT_OUT_OE_O,
    input wire logic DIV2_O,
    input wire logic DIV256_O,
    input wire logic CARRY_O,
    input wire logic BUF_RESET_O,
    input wire logic OSC_HALT_O
);
    default clocking @(posedge CORE_CLK_I); endclocking
    default disable iff (!RSTN_I);
    a_trig_runs: assert property (TRIGGER_I |-> ##2 !BUF_RESET_O)
        else $error("trigger did not start the run");
    a_reset_stops: assert property (RESET_I && !TRIGGER_I |-> ##2 BUF_RESET_O)
        else $error("reset did not stop the counter");
    a_trig_wins: assert property (TRIGGER_I && RESET_I |=> ##1 !BUF_RESET_O)
        else $error("reset overrode trigger");
    a_run_zero: assert property ($fell(BUF_RESET_O) && TIMING_NODE_GND_I
        && !$past(TIMEBASE_PIN_I, 2) |-> CNT_OUT_OE_O == 8'hFF) else $error("run not zeroed");
    a_stop_high: assert property (BUF_RESET_O |-> CNT_OUT_OE_O == 8'h00)
        else $error("stopped outputs not high");
    a_osc_halt: assert property (BUF_RESET_O && !TIMING_NODE_GND_I &&
        !$past(TIMING_NODE_GND_I) |-> OSC_HALT_O) else $error("oscillator not halted");
    a_div_bits: assert property (DIV2_O == !CNT_OUT_OE_O[0] && DIV256_O == !CNT_OUT_OE_O[7])
        else $error("divider outputs disagree with count");
    a_ext_input: assert property (TIMING_NODE_GND_I && $past(TIMING_NODE_GND_I)
        |-> !TIMEBASE_PIN_OE_O) else $error("timebase pin driven in external mode");
    a_carry_idle: assert property (BUF_RESET_O |-> !CARRY_O)
        else $error("carry high while stopped");
    c_run: cover property ($fell(BUF_RESET_O));
    c_stop: cover property ($rose(BUF_RESET_O));
    c_halt: cover property (BUF_RESET_O && OSC_HALT_O && !TIMING_NODE_GND_I);
endmodule : ttc_chk
bind ttc_timer_counter ttc_chk u_chk (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
    .TRIGGER_I(TRIGGER_I), .RESET_I(RESET_I), .TIMING_NODE_GND_I(TIMING_NODE_GND_I),
    .TIMEBASE_PIN_I(TIMEBASE_PIN_I), .TIMEBASE_PIN_OE_O(TIMEBASE_PIN_OE_O),
    .CNT_OUT_OE_O(CNT_OUT_OE_O), .DIV2_O(DIV2_O), .DIV256_O(DIV256_O), .CARRY_O(CARRY_O),
    .BUF_RESET_O(BUF_RESET_O), .OSC_HALT_O(OSC_HALT_O));
`default_nettype wire

// >>> testbench/ttc_src.sv
// external timebase source and wired reset feedback network
`timescale 1ns/10ps
`default_nettype none
module ttc_src (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [31:0] want_i,
    input wire logic [7:0] sel_i,
    input wire logic [7:0] oe_i,
    output logic tb_o,
    output logic [31:0] falls_o,
    output logic fb_o
);
    // external clock: runs only while falls are owed, idles low
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tb_o <= 1'b0;
            falls_o <= 32'h0;
        end else if (tb_o || falls_o < want_i) begin
            tb_o <= ~tb_o;
            falls_o <= falls_o + {31'h0, tb_o};
        end
    end
    // shared pull-up rises only when every selected output is released
    assign fb_o = (sel_i != 8'h00) && ((oe_i & sel_i) == 8'h00);
endmodule : ttc_src
`default_nettype wire

// >>> testbench/tb_top.sv
// self-checking bench, external timebase mode, then internal oscillator mode
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, rstn = 1'b0, trig = 1'b0, rst = 1'b0, fb_en = 1'b0, gnd = 1'b1, run = 1'b0;
    logic [31:0] want = 32'h0, falls;
    logic [7:0] sel = 8'h00, oe;
    logic tb, fb, rst_in, tb_out, tb_oe, div2, div256, carry, buf_rst, halt;
    int error_cnt = 0, total_checks = 0, exp_cnt = 255, n;
    assign rst_in = fb_en ? fb : rst;
    always #5 clk = ~clk;
    ttc_timer_counter #(.VARIANT(ttc_pkg::TTC_BINARY), .RC_CYCLES(5)) DUT (.CORE_CLK_I(clk),
        .RSTN_I(rstn), .TRIGGER_I(trig), .RESET_I(rst_in), .TIMING_NODE_GND_I(gnd),
        .TIMEBASE_PIN_I(tb), .TIMEBASE_PIN_O(tb_out), .TIMEBASE_PIN_OE_O(tb_oe),
        .CNT_OUT_OE_O(oe), .DIV2_O(div2), .DIV256_O(div256), .CARRY_O(carry),
        .BUF_RESET_O(buf_rst), .OSC_HALT_O(halt));
    ttc_src src (.clk_i(clk), .rstn_i(rstn), .want_i(want), .sel_i(sel), .oe_i(oe),
        .tb_o(tb), .falls_o(falls), .fb_o(fb));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : summarize
    task automatic step(input int c);
        repeat (c) @(posedge clk);
    endtask : step
    // count, divider outputs and run flag against the model
    task automatic cnt_chk(input string s);
        chk({24'h0, ~oe}, exp_cnt & 255);
        chk({31'h0, div2}, exp_cnt & 1);
        chk({31'h0, div256}, (exp_cnt >> 7) & 1);
        chk({31'h0, buf_rst}, {31'h0, !run});
        $display("test %s done", s);
    endtask : cnt_chk
    task automatic edges(input int k);
        int w;
        w = 0;
        want <= falls + k;
        step(1);
        while (falls < want && w < 3000) begin
            step(1);
            w++;
        end
        if (w == 3000) begin
            error_cnt++;
            summarize();
        end
        step(4);
        if (run) exp_cnt = (exp_cnt + k) % 256;
    endtask : edges
    // trigger held a few cycles, as the feedback delay network would
    task automatic fire();
        trig <= 1'b1;
        step(3);
        trig <= 1'b0;
        step(3);
        run = 1'b1;
        exp_cnt = 0;
    endtask : fire
    // internal oscillator: count falls seen on the timebase pin
    task automatic osc_run();
        int f, w;
        logic p;
        f = 0;
        w = 0;
        p = tb_out;
        repeat (40) begin
            step(1);
            if (p && !tb_out) f++;
            p = tb_out;
        end
        step(1);
        while (!(p && !tb_out) && w < 20) begin
            p = tb_out;
            step(1);
            w++;
        end
        if (w == 20) begin
            error_cnt++;
            summarize();
        end
        f++;
        step(2);
        // trigger came with the pin high, so the first fall only loads zero
        chk({24'h0, ~oe}, f - 1);
        chk({31'h0, buf_rst}, 32'h0);
        $display("test internal oscillator done");
    endtask : osc_run
    initial begin
        void'($urandom(79));
        step(10);
        rstn <= 1'b1;
        step(3);
        cnt_chk("reset");
        edges(3);
        cnt_chk("stopped edges");
        fire();
        cnt_chk("trigger");
        n = $urandom % 200 + 1;
        edges(n);
        cnt_chk("random count");
        edges(300);
        cnt_chk("wrap");
        rst <= 1'b1;
        trig <= 1'b1;
        step(3);
        chk({31'h0, buf_rst}, 32'h0);
        trig <= 1'b0;
        step(3);
        run = 1'b0;
        exp_cnt = 255;
        cnt_chk("reset stops");
        rst <= 1'b0;
        sel <= 8'h05;
        fb_en <= 1'b1;
        fire();
        edges(20);
        run = 1'b0;
        exp_cnt = 255;
        cnt_chk("programmed delay");
        fb_en <= 1'b0;
        gnd <= 1'b0;
        step(3);
        chk({31'h0, halt}, 32'h1);
        chk({31'h0, tb_oe}, 32'h1);
        chk({31'h0, tb_out}, 32'h1);
        fire();
        osc_run();
        summarize();
    end
endmodule : tb_top
`default_nettype wire
